// *** rtl/modbus_mapping_register_slave.sv ***
// Purpose: serial slave serving reads and single writes of mapping words
// Assumes: rx_end pulses in the gap after a frame, never with a byte
// Notes: only 8-byte frames (codes 03 and 06) are answered
`timescale 1ns/1ps
`include "modbus_map_defs.svh"
module modbus_mapping_register_slave (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] slave_addr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   input wire logic rx_end,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic fwd_valid,
   output modbus_map_pkg::fwd_type fwd,
   input wire logic fwd_ready,
   input wire logic upd_valid,
   input wire modbus_map_pkg::upd_type upd,
   output logic upd_ready
);
   import modbus_map_pkg::*;

   core_type s;
   core_type next_s;
   logic [15:0] reg_addr;
   logic [15:0] reg_val;
   logic [15:0] off;
   logic [16:0] last_addr;
   logic addr_ok;
   logic crc_ok;
   logic rd_ok;
   logic wr_ok;
   logic we_mb;
   logic hs;
   logic [7:0] out_byte;
   logic [7:0] body_idx;
   logic [`MAP_AW-1:0] raddr;
   logic [15:0] rdata;
   state_type done_st;

   // R15 reflected check update
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // R3 start and count are big-endian words
   assign reg_addr = {s.frame[2], s.frame[3]};
   assign reg_val = {s.frame[4], s.frame[5]};
   assign off = reg_addr - `MAP_BASE;
   assign last_addr = {1'b0, reg_addr} + {1'b0, reg_val} - 17'h00001;

   // R2 own address, legal range only
   assign addr_ok = s.frame[0] == slave_addr && slave_addr >= `ADDR_MIN &&
                    slave_addr <= `ADDR_MAX;
   // R6 R11 whole frame incl. check leaves zero
   assign crc_ok = s.crc == `CRC_RESIDUE;
   // R8 whole span inside mapping region
   assign rd_ok = addr_ok && crc_ok && s.frame[1] == `FC_READ &&
                  reg_val >= `READ_MIN && reg_val <= `READ_MAX &&
                  reg_addr >= `MAP_BASE && last_addr <= {1'b0, `MAP_LAST};
   // R7 single register write decode
   assign wr_ok = addr_ok && crc_ok && s.frame[1] == `FC_WRITE &&
                  reg_addr >= `MAP_BASE && reg_addr <= `MAP_LAST;
   // R13 code 16 and others fall through to discard

   assign we_mb = s.st == S_CHECK && wr_ok;
   // Modbus write wins the single write port for that one cycle
   assign upd_ready = !we_mb;

   assign body_idx = s.tx_idx - `RD_HDR_LEN;
   assign raddr = off[`MAP_AW-1:0] + {2'b00, body_idx[7:1]};

   map_memory u_mem (
      .ref_clk(ref_clk),
      .ce(ce),
      .we(we_mb || upd_valid),
      .waddr(we_mb ? off[`MAP_AW-1:0] : upd.index),
      .wdata(we_mb ? reg_val : upd.data),
      .raddr(raddr),
      .rdata(rdata)
   );

   always_comb begin
      out_byte = 8'h00;
      // R1 check field low byte then high byte
      if (s.tx_idx == s.tx_len - `CRC_LEN) begin
         out_byte = s.crc[7:0];
      end else if (s.tx_idx == s.tx_len - 8'h01) begin
         out_byte = s.crc[15:8];
      end else if (!s.is_read) begin
         // R10 echo replays request bytes
         out_byte = s.frame[s.tx_idx[2:0]];
      end else if (s.tx_idx == 8'h00) begin
         out_byte = s.frame[0];
      end else if (s.tx_idx == 8'h01) begin
         out_byte = `FC_READ;
      end else if (s.tx_idx == 8'h02) begin
         // R4 byte count is twice the count
         out_byte = {reg_val[6:0], 1'b0};
      end else begin
         // R9 high byte first; R14 words go out raw
         out_byte = body_idx[0] ? rdata[7:0] : rdata[15:8];
      end
   end

   assign done_st = (s.gap_seen || rx_end) ? S_IDLE : S_SKIP;
   assign hs = ce && s.tx_valid && tx_ready;

   always_comb begin
      next_s = s;
      if (rx_end && s.st != S_IDLE) begin
         next_s.gap_seen = 1'b1;
      end
      case (s.st)
         S_IDLE: begin
            if (rx_end) begin
               next_s.rx_cnt = 3'h0;
               next_s.crc = `CRC_INIT;
            end else if (rx_valid) begin
               next_s.frame[s.rx_cnt] = rx_data;
               next_s.crc = crc_step(s.crc, rx_data);
               next_s.rx_cnt = s.rx_cnt + 3'h1;
               if (s.rx_cnt == `FRAME_LAST) begin
                  next_s.gap_seen = 1'b0;
                  next_s.st = S_CHECK;
               end
            end
         end
         S_CHECK: begin
            next_s.tx_idx = 8'h00;
            next_s.crc = `CRC_INIT;
            next_s.rx_cnt = 3'h0;
            if (rd_ok) begin
               // R5 length is header, 2n data, check
               next_s.is_read = 1'b1;
               next_s.tx_len = `RD_HDR_LEN + `CRC_LEN + {reg_val[6:0], 1'b0};
               next_s.st = S_FETCH;
            end else if (wr_ok) begin
               next_s.is_read = 1'b0;
               next_s.tx_len = `FRAME_LEN;
               next_s.st = S_FWD;
            end else begin
               // R16 silent discard
               next_s.st = done_st;
            end
         end
         S_FWD: begin
            // R12 echo waits until downstream took the write
            if (fwd_ready) begin
               next_s.st = S_FETCH;
            end
         end
         S_FETCH: begin
            next_s.st = S_LOAD;
         end
         S_LOAD: begin
            next_s.tx_data = out_byte;
            next_s.tx_valid = 1'b1;
            if (s.tx_idx < s.tx_len - `CRC_LEN) begin
               next_s.crc = crc_step(s.crc, out_byte);
            end
            next_s.st = S_SEND;
         end
         S_SEND: begin
            if (tx_ready) begin
               next_s.tx_valid = 1'b0;
               if (s.tx_idx == s.tx_len - 8'h01) begin
                  next_s.crc = `CRC_INIT;
                  next_s.st = done_st;
               end else begin
                  next_s.tx_idx = s.tx_idx + 8'h01;
                  next_s.st = S_FETCH;
               end
            end
         end
         S_SKIP: begin
            // absorb the tail of longer frames until the gap
            if (rx_end) begin
               next_s.st = S_IDLE;
            end
         end
         default: begin
            next_s.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{st: S_IDLE, crc: `CRC_INIT, default: '0};
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign rx_ready = s.st == S_IDLE || s.st == S_SKIP;
   assign tx_valid = s.tx_valid;
   assign tx_data = s.tx_data;
   assign fwd_valid = s.st == S_FWD;
   assign fwd.addr = reg_addr;
   assign fwd.data = reg_val;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence low_sent;
      hs && s.tx_idx == s.tx_len - `CRC_LEN;
   endsequence
   sequence next_byte_up;
      ce [*3];
   endsequence
   sequence write_taken;
      ce && s.st == S_CHECK && wr_ok;
   endsequence

   crc_order_a: assert property ( // R1
      low_sent ##1 next_byte_up |-> tx_valid && tx_data == s.crc[15:8])
      else $error("check high byte not sent after low byte");

   addr_gate_a: assert property ( // R2
      ce && s.st == S_CHECK && (rd_ok || wr_ok) |=>
      s.frame[0] == slave_addr && slave_addr >= `ADDR_MIN &&
      slave_addr <= `ADDR_MAX)
      else $error("frame answered for foreign address");

   byte_count_a: assert property ( // R4
      hs && s.is_read && s.tx_idx == 8'h02 |->
      tx_data == {s.frame[5][6:0], 1'b0})
      else $error("byte count not twice register count");

   read_len_a: assert property ( // R5
      ce && s.st == S_CHECK && rd_ok |=>
      s.tx_len == `RD_HDR_LEN + `CRC_LEN + {s.frame[5][6:0], 1'b0} &&
      s.st == S_FETCH)
      else $error("read answer length wrong");

   echo_body_a: assert property ( // R10
      hs && !s.is_read && s.tx_idx < `ECHO_BODY |->
      tx_data == s.frame[s.tx_idx[2:0]])
      else $error("write echo differs from request");

   echo_check_a: assert property ( // R11
      hs && !s.is_read && s.tx_idx >= `ECHO_BODY |->
      tx_data == s.frame[s.tx_idx[2:0]])
      else $error("echoed check field differs");

   map_range_a: assert property ( // R8
      ce && s.st == S_FETCH && s.is_read && s.tx_idx >= `RD_HDR_LEN &&
      s.tx_idx < s.tx_len - `CRC_LEN |->
      {7'h00, raddr} <= `MAP_LAST - `MAP_BASE && reg_addr >= `MAP_BASE)
      else $error("read outside mapping region");

   fwd_value_a: assert property ( // R12
      write_taken |=> fwd_valid && fwd.data == {s.frame[4], s.frame[5]} &&
      fwd.addr == {s.frame[2], s.frame[3]})
      else $error("write not forwarded downstream");

   discard_a: assert property ( // R16
      ce && s.st == S_CHECK && !(rd_ok || wr_ok) |=>
      (!tx_valid && !fwd_valid) [*3])
      else $error("bad frame produced a response");
endmodule // modbus_mapping_register_slave

// *** rtl/modbus_map_defs.svh ***
// Purpose: constants of the mapping register slave
// Assumes: frames arrive as bytes with an end-of-frame gap pulse
// Notes: Operation list below
//
// Operation
// R1: check field two bytes, low first
// R2: answer only own address 1..247
// R3: read request: address, 03, start, count
// R4: byte count twice register count, two bytes each
// R5: ten registers answer with count 14h
// R6: known request and answer check values hold
// R7: code 06 writes one holding register
// R8: only addresses 4e20h to 501ch accepted
// R9: register values travel high byte first
// R10: successful write echoes request unchanged
// R11: write example carries check 9e c3
// R12: changed value forwarded to downstream slave
// R13: multi-register writes use code 16
// R14: master interprets raw words itself
// R15: check is reflected a001, start ffff
// R16: bad check or address: silent discard
`ifndef MODBUS_MAP_DEFS_SVH
`define MODBUS_MAP_DEFS_SVH

`define FC_READ 8'h03
`define FC_WRITE 8'h06
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'hf7
`define MAP_BASE 16'h4e20
`define MAP_LAST 16'h501c
`define MAP_DEPTH 509
`define MAP_AW 9
`define READ_MIN 16'h0001
`define READ_MAX 16'h007d
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define CRC_RESIDUE 16'h0000
`define CRC_LEN 8'h02
`define RD_HDR_LEN 8'h03
`define FRAME_LEN 8'h08
`define FRAME_LAST 3'h7
`define ECHO_BODY 8'h06

`endif

// *** rtl/modbus_map_pkg.sv ***
// Purpose: types of the mapping register slave
// Assumes: constants come from the defs header
// Notes: state is one-hot
`include "modbus_map_defs.svh"
package modbus_map_pkg;

   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_CHECK = 7'h02,
      S_FWD   = 7'h04,
      S_FETCH = 7'h08,
      S_LOAD  = 7'h10,
      S_SEND  = 7'h20,
      S_SKIP  = 7'h40
   } state_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } fwd_type;

   typedef struct packed {
      logic [`MAP_AW-1:0] index;
      logic [15:0] data;
   } upd_type;

   typedef struct packed {
      state_type st;
      logic [7:0][7:0] frame;
      logic [2:0] rx_cnt;
      logic gap_seen;
      logic [15:0] crc;
      logic [7:0] tx_idx;
      logic [7:0] tx_len;
      logic [7:0] tx_data;
      logic tx_valid;
      logic is_read;
   } core_type;

endpackage

// *** rtl/map_memory.sv ***
// Purpose: mirror of the mapping holding registers
// Assumes: one write and one read per cycle
// Notes: read data registered, one cycle latency
`timescale 1ns/1ps
`include "modbus_map_defs.svh"
module map_memory (
   input wire logic ref_clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [`MAP_AW-1:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [`MAP_AW-1:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:`MAP_DEPTH-1];

   // no reset: contents are data, not control
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule // map_memory

// *** sim/modbus_master_model.sv ***
// Purpose: serial master polling the mapping register slave
// Assumes: byte handshake on rx_valid/rx_ready, rx_end gap held until one enabled edge
// Notes: tx_ready stalls at random so answers are taken fast and slow
`timescale 1ns/1ps
module modbus_master_model (
   input wire logic ref_clk,
   input wire logic ce,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   output logic tx_ready,
   output logic fail
);
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_end = 1'b0;
      tx_ready = 1'b0;
      fail = 1'b0;
   end

   always @(posedge ref_clk) begin
      #1 tx_ready = ($urandom_range(3) != 0);
   end

   function automatic logic [15:0] crc16(input logic [7:0] q [$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction

   // body, then check low byte first
   task automatic send(input logic [7:0] q [$], input logic bad);
      logic [15:0] c;
      int n;
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      rx_valid = 1'b1;
      foreach (q[i]) begin
         rx_data = q[i];
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (!(rx_ready === 1'b1 && ce === 1'b1) && n < 3000);
         if (n >= 3000) fail = 1'b1;
         #1;
      end
      // released line shows no stale byte
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      rx_end = 1'b1;
      // the gap pulse only counts on an enabled edge
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ce !== 1'b1 && n < 3000);
      if (n >= 3000) fail = 1'b1;
      #1 rx_end = 1'b0;
   endtask
endmodule // modbus_master_model

// *** sim/modbus_mapping_register_slave_tb.sv ***
// Purpose: self-checking bench of the mapping register slave
// Assumes: a tb mirror of all words, loaded through the update port
// Notes: expected bytes queued by the driver, popped by the monitor
`timescale 1ns/1ps
module modbus_mapping_register_slave_tb;
   import modbus_map_pkg::*;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] slave_addr = 8'h01;
   logic rx_valid, rx_ready, rx_end, tx_valid, tx_ready, fail;
   logic [7:0] rx_data, tx_data;
   logic fwd_valid, upd_ready;
   logic fwd_ready = 1'b0;
   logic upd_valid = 1'b0;
   fwd_type fwd;
   upd_type upd = '0;
   logic [7:0] exp_tx [$];
   fwd_type exp_fwd [$];
   logic [15:0] mirror [0:508];
   logic [15:0] doc [10] = '{16'h0014, 16'h001e, 16'h0028, 16'h0032,
      16'h004b, 16'h0041, 16'h000a, 16'h0025, 16'h0014, 16'h002a};
   int errors = 0;
   int tests_run = 0;

   modbus_mapping_register_slave u_dut (.ref_clk, .rst_n, .ce,
      .slave_addr, .rx_valid, .rx_data, .rx_ready, .rx_end, .tx_valid,
      .tx_data, .tx_ready, .fwd_valid, .fwd, .fwd_ready, .upd_valid,
      .upd, .upd_ready);
   modbus_master_model u_master (.ref_clk, .ce, .rx_ready, .rx_valid,
      .rx_data, .rx_end, .tx_ready, .fail);

   always #2.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      #1 fwd_ready = 1'($urandom_range(1));
      // frozen cycles prove every handshake waits for ce
      ce = ($urandom_range(7) != 0);
   end

   always @(posedge ref_clk) begin
      logic [7:0] eb;
      fwd_type ef;
      if (ce === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         eb = exp_tx.size() ? exp_tx.pop_front() : 8'hxx;
         `CHK("tx_data", eb, tx_data)
      end
      if (ce === 1'b1 && fwd_valid === 1'b1 && fwd_ready === 1'b1) begin
         ef = exp_fwd.size() ? exp_fwd.pop_front() : 'x;
         `CHK("fwd", ef, fwd)
      end
   end

   always @(posedge fail) begin
      errors++;
      end_sim();
   end

   task automatic end_sim;
      $display("comparisons %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic put(input int i, input logic [15:0] d);
      int n;
      upd_valid = 1'b1;
      upd = '{i[8:0], d};
      mirror[i] = d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(upd_ready === 1'b1 && ce === 1'b1) && n < 50);
      if (n >= 50) end_sim();
      #1;
   endtask

   // expected answer, raw words high byte first
   task automatic xfer(input logic [7:0] q [$], input logic ok, bad);
      logic [15:0] c, a;
      logic [7:0] r [$];
      int n;
      a = {q[2], q[3]} - 16'h4e20;
      n = {q[4], q[5]};
      r = q;
      if (ok && q[1] == 8'h06) begin
         exp_fwd.push_back({q[2], q[3], q[4], q[5]});
         mirror[a] = {q[4], q[5]};
      end else if (ok) begin
         r = {q[0], q[1], 8'(2 * n)};
         for (int i = 0; i < n; i++) begin
            r.push_back(mirror[a + 16'(i)][15:8]);
            r.push_back(mirror[a + 16'(i)][7:0]);
         end
      end
      c = u_master.crc16(r);
      if (ok) exp_tx = {exp_tx, r, c[7:0], c[15:8]};
      u_master.send(q, bad);
   endtask

   task automatic drain;
      int n;
      n = 0;
      while ((exp_tx.size() || exp_fwd.size()) && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 3000) begin
         errors++;
         end_sim();
      end
      repeat (20) @(posedge ref_clk);
      // step off the edge before the next frame is driven
      #1;
   endtask

   initial begin
      int a, n;
      logic [15:0] w;
      void'($urandom(57844));
      repeat (20) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 509; i++) put(i, i < 10 ? doc[i] : 16'($urandom));
      upd_valid = 1'b0;
      xfer({8'h01, 8'h03, 8'h4e, 8'h20, 8'h00, 8'h0a}, 1, 0);
      xfer({8'h01, 8'h06, 8'h4e, 8'h20, 8'h00, 8'h64}, 1, 0);
      xfer({8'h01, 8'h03, 8'h4e, 8'h20, 8'h00, 8'h01}, 1, 0);
      xfer({8'h01, 8'h06, 8'h50, 8'h1c, 8'hbe, 8'hef}, 1, 0);
      xfer({8'h01, 8'h03, 8'h50, 8'h1c, 8'h00, 8'h01}, 1, 0);
      xfer({8'h01, 8'h03, 8'h4e, 8'h20, 8'h00, 8'h7d}, 1, 0);
      xfer({8'h02, 8'h06, 8'h4e, 8'h20, 8'h00, 8'h01}, 0, 0);
      xfer({8'h01, 8'h06, 8'h4e, 8'h20, 8'h00, 8'h01}, 0, 1);
      xfer({8'h01, 8'h06, 8'h50, 8'h1d, 8'h00, 8'h01}, 0, 0);
      xfer({8'h01, 8'h06, 8'h4d, 8'hff, 8'h00, 8'h01}, 0, 0);
      xfer({8'h01, 8'h03, 8'h50, 8'h1c, 8'h00, 8'h02}, 0, 0);
      xfer({8'h01, 8'h03, 8'h4e, 8'h20, 8'h00, 8'h00}, 0, 0);
      xfer({8'h01, 8'h03, 8'h4e, 8'h20, 8'h00, 8'h7e}, 0, 0);
      xfer({8'h01, 8'h10, 8'h4e, 8'h20, 8'h00, 8'h01}, 0, 0);
      drain();
      slave_addr = 8'hf7;
      xfer({8'hf7, 8'h06, 8'h4e, 8'h21, 8'h12, 8'h34}, 1, 0);
      drain();
      slave_addr = 8'h01;
      repeat (6) begin
         a = $urandom_range(508);
         n = $urandom_range(4, 1);
         if (a + n > 509) a = 509 - n;
         w = 16'h4e20 + 16'(a);
         xfer({8'h01, 8'h06, w[15:8], w[7:0], 8'($urandom), 8'($urandom)},
            1, 0);
         xfer({8'h01, 8'h03, w[15:8], w[7:0], 8'h00, 8'(n)}, 1, 0);
      end
      drain();
      end_sim();
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      end_sim();
   end
endmodule // modbus_mapping_register_slave_tb
